// *** design/lomsel_pkg.sv ***
// constants for the loop output and mode selection block
package lomsel_pkg;
  localparam int MVW = 16;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ALM_OUT = 8'h04;
  localparam logic [7:0] OFS_RDY_HEAT = 8'h08;
  localparam logic [7:0] OFS_RDY_COOL = 8'h0C;
  localparam logic [7:0] OFS_PRESET_MAN = 8'h10;
  localparam logic [7:0] OFS_PID_INIT = 8'h14;
  localparam logic [7:0] OFS_ONOFF_DIFF = 8'h18;
  localparam logic [7:0] OFS_ONOFF_ONOFF_POINT_OFFSET = 8'h1C;
  localparam logic [7:0] OFS_SETPOINT = 8'h20;
  localparam logic [7:0] OFS_SP_GROUP = 8'h24;
  localparam logic [7:0] OFS_ITIME = 8'h28;
  localparam logic [7:0] OFS_DTIME = 8'h2C;
  localparam logic [7:0] OFS_PID_MV = 8'h30;
  localparam logic [7:0] OFS_MAN_MV = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'h38;
  // control register fields
  localparam int CB_METHOD = 0;
  localparam int CB_ACTION = 1;
  localparam int CB_HEATCOOL = 2;
  localparam int CB_ALM_SEL = 3;
  localparam int CB_XFER = 4;
  localparam int CB_INIT_LO = 5;
  localparam int CB_DP = 7;
  localparam int CB_MANUAL = 8;
  localparam int CB_RUN = 9;
  localparam int CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h001;
  // fixed point MV limits, 0.1 % per count
  localparam logic signed [MVW-1:0] MV_MIN = -16'sd100;
  localparam logic signed [MVW-1:0] MV_MAX = 16'sd1100;
  localparam logic signed [MVW-1:0] MV_FULL = 16'sd1000;
  localparam logic signed [MVW-1:0] MV_ZERO = 16'sd0;
  localparam logic signed [MVW-1:0] MV_HALF = 16'sd500;
  localparam logic signed [MVW-1:0] ONOFF_POINT_OFFSET_MIN = -16'sd1999;
  localparam logic signed [MVW-1:0] ONOFF_POINT_OFFSET_MAX = 16'sd9999;
  localparam logic signed [MVW-1:0] DIFF_RST = 16'sd5;
  localparam logic [15:0] TIME_MAX = 16'd9999;
  localparam logic [15:0] ITIME_RST = 16'd120;
  localparam logic [15:0] DTIME_RST = 16'd30;
  localparam logic [4:0] TIME_SCALE = 5'd10;
  localparam logic [1:0] INIT_AUTO = 2'd0;
  localparam logic [1:0] INIT_NEVER = 2'd1;
  localparam logic [1:0] INIT_ALWAYS = 2'd2;
endpackage : lomsel_pkg

// *** design/lomsel_top.sv ***
// output selection, mode transitions and on/off control with apb registers
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/100ps

// Functional notes
// - pv alarm: continue or drive alarm value
// - alarm is any of three alarm inputs
// - ready drives heat ready value, default zero
// - cool ready value only with pid heat/cool
// - auto to manual: hold or preset mv
// - preset manual default follows heat/cool enable
// - manual at power-up loads preset value only with manual set, which reset clears
// - init type 0: reinit when group changes
// - init type 1: never reinit
// - init type 2: reinit on every change
// - seed pid on ready-to-run write; boot seeds only with run set, which reset clears
// - heat/cool change reloads pid initial output
// - decimal point selects time scaling
// - time counts kept when decimal changes
// - on/off settings only in on/off method
// - reverse on/off: off at threshold, hysteresis
// - direct on/off: off at or below threshold
// - reverse lowers mv, direct raises mv
module lomsel_top (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // process side
  input wire logic signed [lomsel_pkg::MVW-1:0] PV_I,
  input wire logic PV_ALARM_ONE_I,
  input wire logic PV_ALARM_TWO_I,
  input wire logic PV_ALARM_THREE_I,
  // actuator and pid side
  output logic signed [lomsel_pkg::MVW-1:0] MV_O,
  output logic ONOFF_OUT_O,
  output logic PID_REINIT_O,
  output logic PID_SEED_O,
  output logic signed [lomsel_pkg::MVW-1:0] PID_SEED_VAL_O,
  output logic [16:0] ITIME_EFF_O,
  output logic [16:0] DTIME_EFF_O
);
  import lomsel_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic signed [MVW-1:0] alm_out;
    logic signed [MVW-1:0] rdy_heat;
    logic signed [MVW-1:0] rdy_cool;
    logic signed [MVW-1:0] preset_man;
    logic signed [MVW-1:0] pid_init;
    logic signed [MVW-1:0] diff;
    logic signed [MVW-1:0] onoff_point_offset;
    logic signed [MVW-1:0] sp;
    logic [1:0] sp_group;
    logic [15:0] itime;
    logic [15:0] dtime;
    logic signed [MVW-1:0] pid_mv;
    logic signed [MVW-1:0] mv;
    logic onoff;
    logic boot;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic reinit;
    logic seed;
    logic [16:0] ieff;
    logic [16:0] deff;
  } lomsel_state_t;

  lomsel_state_t s_q, s_d;

  function automatic logic signed [MVW-1:0] clamp_mv(
    input logic [31:0] w
  );
    logic signed [MVW-1:0] v;
    v = w[MVW-1:0];
    if (v < MV_MIN) begin
      clamp_mv = MV_MIN;
    end else if (v > MV_MAX) begin
      clamp_mv = MV_MAX;
    end else begin
      clamp_mv = v;
    end
  endfunction : clamp_mv

  function automatic logic [15:0] clamp_time(input logic [31:0] w);
    clamp_time = (w[15:0] > TIME_MAX) ? TIME_MAX : w[15:0];
  endfunction : clamp_time

  logic access;
  logic wr;
  logic is_pid;
  logic is_onoff;
  logic cool_vis;
  logic alarm;
  logic mapped;
  logic signed [MVW+1:0] thr;
  logic signed [MVW+1:0] pv_x;
  logic signed [MVW+1:0] diff_x;
  logic signed [MVW-1:0] wv;
  logic [CTRL_W-1:0] nctrl;
  logic sp_chg;
  logic grp_chg;

  always_comb begin
    s_d = s_q;
    s_d.reinit = 1'b0;
    s_d.seed = 1'b0;
    s_d.boot = 1'b0;
    // second cycle of access phase completes, so pready is a flop
    access = PSEL_I & PENABLE_I & ~s_q.pready;
    wr = PSEL_I & PENABLE_I & s_q.pready & PWRITE_I;
    s_d.pready = access;
    is_onoff = ~s_q.ctrl[CB_METHOD];
    is_pid = s_q.ctrl[CB_METHOD];
    cool_vis = is_pid & s_q.ctrl[CB_HEATCOOL];
    alarm = PV_ALARM_ONE_I | PV_ALARM_TWO_I | PV_ALARM_THREE_I;
    wv = clamp_mv(PWDATA_I);
    nctrl = PWDATA_I[CTRL_W-1:0];
    sp_chg = 1'b0;
    grp_chg = 1'b0;
    mapped = 1'b1;
    s_d.prdata = 32'h0000_0000;
    case (PADDR_I)
      OFS_CTRL: s_d.prdata = {22'h00_0000, s_q.ctrl};
      OFS_ALM_OUT: s_d.prdata = {{16{s_q.alm_out[MVW-1]}}, s_q.alm_out};
      OFS_RDY_HEAT: s_d.prdata = {{16{s_q.rdy_heat[MVW-1]}}, s_q.rdy_heat};
      OFS_RDY_COOL: s_d.prdata = cool_vis ?
        {{16{s_q.rdy_cool[MVW-1]}}, s_q.rdy_cool} : 32'h0000_0000;
      OFS_PRESET_MAN:
        s_d.prdata = {{16{s_q.preset_man[MVW-1]}}, s_q.preset_man};
      OFS_PID_INIT: s_d.prdata = {{16{s_q.pid_init[MVW-1]}}, s_q.pid_init};
      OFS_ONOFF_DIFF: s_d.prdata = is_onoff ?
        {{16{s_q.diff[MVW-1]}}, s_q.diff} : 32'h0000_0000;
      OFS_ONOFF_ONOFF_POINT_OFFSET: s_d.prdata = is_onoff ?
        {{16{s_q.onoff_point_offset[MVW-1]}}, s_q.onoff_point_offset} : 32'h0000_0000;
      OFS_SETPOINT: s_d.prdata = {{16{s_q.sp[MVW-1]}}, s_q.sp};
      OFS_SP_GROUP: s_d.prdata = {30'h0000_0000, s_q.sp_group};
      OFS_ITIME: s_d.prdata = {16'h0000, s_q.itime};
      OFS_DTIME: s_d.prdata = {16'h0000, s_q.dtime};
      OFS_PID_MV: s_d.prdata = {{16{s_q.pid_mv[MVW-1]}}, s_q.pid_mv};
      OFS_MAN_MV: s_d.prdata = {{16{s_q.mv[MVW-1]}}, s_q.mv};
      OFS_STATUS: s_d.prdata = {29'h0000_0000, alarm, s_q.onoff, 1'b0};
      default: mapped = 1'b0;
    endcase
    s_d.pslverr = access & ~mapped;
    if (~access) begin
      s_d.prdata = 32'h0000_0000;
    end
    if (wr) begin
      case (PADDR_I)
        OFS_CTRL: begin
          s_d.ctrl = nctrl;
          if (nctrl[CB_INIT_LO+:2] == 2'd3) begin
            s_d.ctrl[CB_INIT_LO+:2] = s_q.ctrl[CB_INIT_LO+:2];
          end
          // heat/cool toggled: both presets reload
          if (nctrl[CB_HEATCOOL] != s_q.ctrl[CB_HEATCOOL]) begin
            s_d.pid_init = nctrl[CB_HEATCOOL] ? MV_HALF : MV_ZERO;
            s_d.preset_man = nctrl[CB_HEATCOOL] ? MV_HALF : MV_ZERO;
          end
          // auto to manual transfer
          // transfer mode written with the mode bit applies at once
          if (nctrl[CB_MANUAL] & ~s_q.ctrl[CB_MANUAL] &
              nctrl[CB_XFER]) begin
            s_d.mv = s_q.preset_man;
          end
          if (nctrl[CB_RUN] & ~s_q.ctrl[CB_RUN]) begin
            s_d.seed = 1'b1;
          end
        end
        OFS_ALM_OUT: s_d.alm_out = wv;
        OFS_RDY_HEAT: s_d.rdy_heat = wv;
        OFS_RDY_COOL: begin
          if (cool_vis) begin
            s_d.rdy_cool = wv;
          end
        end
        OFS_PRESET_MAN: s_d.preset_man = wv;
        OFS_PID_INIT: s_d.pid_init = wv;
        OFS_ONOFF_DIFF: begin
          if (is_onoff) begin
            s_d.diff = PWDATA_I[MVW-1] ? MV_ZERO : PWDATA_I[MVW-1:0];
          end
        end
        OFS_ONOFF_ONOFF_POINT_OFFSET: begin
          if (is_onoff) begin
            if ($signed(PWDATA_I[MVW-1:0]) < ONOFF_POINT_OFFSET_MIN) begin
              s_d.onoff_point_offset = ONOFF_POINT_OFFSET_MIN;
            end else if ($signed(PWDATA_I[MVW-1:0]) > ONOFF_POINT_OFFSET_MAX) begin
              s_d.onoff_point_offset = ONOFF_POINT_OFFSET_MAX;
            end else begin
              s_d.onoff_point_offset = PWDATA_I[MVW-1:0];
            end
          end
        end
        OFS_SETPOINT: begin
          s_d.sp = PWDATA_I[MVW-1:0];
          sp_chg = PWDATA_I[MVW-1:0] != s_q.sp;
        end
        OFS_SP_GROUP: begin
          s_d.sp_group = PWDATA_I[1:0];
          grp_chg = PWDATA_I[1:0] != s_q.sp_group;
        end
        OFS_ITIME: s_d.itime = clamp_time(PWDATA_I);
        OFS_DTIME: s_d.dtime = clamp_time(PWDATA_I);
        OFS_PID_MV: s_d.pid_mv = wv;
        OFS_MAN_MV: begin
          if (s_q.ctrl[CB_MANUAL]) begin
            s_d.mv = wv;
          end
        end
        default: s_d.mv = s_q.mv;
      endcase
    end
    // a group change is what swaps pid sets, so auto reinits only then
    case (s_q.ctrl[CB_INIT_LO+:2])
      INIT_AUTO: s_d.reinit = is_pid & grp_chg;
      INIT_NEVER: s_d.reinit = 1'b0;
      INIT_ALWAYS: s_d.reinit = is_pid & (sp_chg | grp_chg);
      default: s_d.reinit = 1'b0;
    endcase
    // stored counts never change; only their meaning does
    // widen first: 9999 x 10 needs 17 bits
    s_d.ieff = s_q.ctrl[CB_DP] ? {1'b0, s_q.itime} :
      17'(s_q.itime) * 17'(TIME_SCALE);
    s_d.deff = s_q.ctrl[CB_DP] ? {1'b0, s_q.dtime} :
      17'(s_q.dtime) * 17'(TIME_SCALE);
    // on/off hysteresis, threshold is setpoint plus offset
    thr = 18'(s_q.sp) + 18'(s_q.onoff_point_offset);
    pv_x = 18'(PV_I);
    diff_x = 18'(s_q.diff);
    if (~s_q.ctrl[CB_ACTION]) begin
      if (pv_x >= thr) begin
        s_d.onoff = 1'b0;
      end else if (pv_x < thr - diff_x) begin
        s_d.onoff = 1'b1;
      end
    end else begin
      if (pv_x <= thr) begin
        s_d.onoff = 1'b0;
      end else if (pv_x > thr + diff_x) begin
        s_d.onoff = 1'b1;
      end
    end
    // mv source; manual keeps its own value while running
    if (s_q.boot) begin
      if (s_q.ctrl[CB_MANUAL]) begin
        s_d.mv = s_q.preset_man;
      end
      s_d.seed = s_q.ctrl[CB_RUN];
    end else if (~s_q.ctrl[CB_RUN]) begin
      s_d.mv = s_q.rdy_heat;
    // new mode, so a transfer value loaded this cycle survives
    end else if (s_d.ctrl[CB_MANUAL]) begin
      s_d.mv = s_d.mv;
    end else if (alarm & s_q.ctrl[CB_ALM_SEL]) begin
      s_d.mv = s_q.alm_out;
    end else if (is_onoff) begin
      s_d.mv = s_d.onoff ? MV_FULL : MV_ZERO;
    end else begin
      s_d.mv = s_q.pid_mv;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      s_q.diff <= DIFF_RST;
      s_q.itime <= ITIME_RST;
      s_q.dtime <= DTIME_RST;
      s_q.boot <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA_O = s_q.prdata;
  assign PREADY_O = s_q.pready;
  assign PSLVERR_O = s_q.pslverr;
  assign MV_O = s_q.mv;
  assign ONOFF_OUT_O = s_q.onoff;
  assign PID_REINIT_O = s_q.reinit;
  assign PID_SEED_O = s_q.seed;
  assign PID_SEED_VAL_O = s_q.pid_init;
  assign ITIME_EFF_O = s_q.ieff;
  assign DTIME_EFF_O = s_q.deff;
endmodule : lomsel_top

// *** sim/lomsel_proc_model.sv ***
// process side model: sensor value and three alarm contacts
`timescale 1ns/100ps
module lomsel_proc_model (
  // clock
  input wire logic clk_i,
  // commanded process state
  input wire logic signed [15:0] pv_set_i,
  input wire logic [2:0] alm_set_i,
  // sensor outputs
  output logic signed [15:0] pv_o,
  output logic [2:0] alm_o
);
  // sensor moves only on the sample clock, never mid-cycle
  always_ff @(posedge clk_i) begin
    pv_o <= pv_set_i;
    alm_o <= alm_set_i;
  end
endmodule : lomsel_proc_model

// *** sim/lomsel_top_monitor.sv ***
// port assertions for the loop output selection block
`timescale 1ns/100ps
module lomsel_top_monitor (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic SRST_I,
  // apb
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic PREADY_O,
  // outputs
  input wire logic signed [lomsel_pkg::MVW-1:0] MV_O,
  input wire logic PID_REINIT_O,
  input wire logic PID_SEED_O,
  input wire logic signed [lomsel_pkg::MVW-1:0] PID_SEED_VAL_O,
  input wire logic [16:0] ITIME_EFF_O,
  input wire logic [16:0] DTIME_EFF_O
);
  import lomsel_pkg::*;
  logic wdone, sp_wr, run_wr;
  assign wdone = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  assign sp_wr = wdone & (PADDR_I == OFS_SETPOINT | PADDR_I == OFS_SP_GROUP);
  assign run_wr = wdone & PADDR_I == OFS_CTRL & PWDATA_I[CB_RUN];
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SRST_I);
  property p_mv_range;
    MV_O >= MV_MIN && MV_O <= MV_MAX;
  endproperty
  a_mv_range: assert property (p_mv_range) else $error("mv range");
  property p_seed_range;
    PID_SEED_O |-> PID_SEED_VAL_O >= MV_MIN && PID_SEED_VAL_O <= MV_MAX;
  endproperty
  a_seed_range: assert property (p_seed_range)
    else $error("seed value range");
  property p_itime_max;
    ITIME_EFF_O <= 17'd99990;
  endproperty
  a_itime_max: assert property (p_itime_max) else $error("itime");
  property p_dtime_max;
    DTIME_EFF_O <= 17'd99990;
  endproperty
  a_dtime_max: assert property (p_dtime_max) else $error("dtime");
  // pulse may land one or two edges after the completing write
  property p_reinit_cause;
    PID_REINIT_O |-> $past(sp_wr) || $past(sp_wr, 2);
  endproperty
  a_reinit_cause: assert property (p_reinit_cause)
    else $error("reinit without setpoint write");
  property p_reinit_pulse;
    PID_REINIT_O |=> !PID_REINIT_O;
  endproperty
  a_reinit_pulse: assert property (p_reinit_pulse)
    else $error("reinit longer than one cycle");
  property p_seed_cause;
    $rose(PID_SEED_O) |-> $past(run_wr) || $past(run_wr, 2);
  endproperty
  a_seed_cause: assert property (p_seed_cause)
    else $error("seed without run write");
  property p_seed_pulse;
    PID_SEED_O |=> !PID_SEED_O;
  endproperty
  a_seed_pulse: assert property (p_seed_pulse)
    else $error("seed longer than one cycle");
  c_reinit: cover property (PID_REINIT_O);
  c_seed: cover property (PID_SEED_O);
  c_mv_low: cover property (MV_O < MV_ZERO);
endmodule : lomsel_top_monitor

bind lomsel_top lomsel_top_monitor u_mon (.CORE_CLK_I(CORE_CLK_I),
  .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PREADY_O(PREADY_O), .MV_O(MV_O), .PID_REINIT_O(PID_REINIT_O),
  .PID_SEED_O(PID_SEED_O), .PID_SEED_VAL_O(PID_SEED_VAL_O),
  .ITIME_EFF_O(ITIME_EFF_O), .DTIME_EFF_O(DTIME_EFF_O));

// *** sim/lomsel_tb_top.sv ***
// self-checking bench for the loop output selection block
`timescale 1ns/100ps
module lomsel_tb_top;
  import lomsel_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic signed [15:0] pv_set = 16'sh0000, pv, mv, sv;
  logic [2:0] alm_set = 3'h0, alm;
  logic pready, pslverr, onoff, reinit, seed;
  logic [16:0] itime, dtime;
  logic [32:0] expq[$];
  int fails = 0, num_checks = 0, reinit_n = 0, seed_n = 0;
  int h, r, a, i;
  int pvs[10] = '{210, 195, 189, 200, 205, 5, 8, 11, 6, 5};
  logic [9:0] on_pat = 10'h18c;
  always #10 clk = ~clk;
  lomsel_top DUT (.CORE_CLK_I(clk), .SRST_I(srst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .PV_I(pv), .PV_ALARM_ONE_I(alm[0]),
    .PV_ALARM_TWO_I(alm[1]), .PV_ALARM_THREE_I(alm[2]), .MV_O(mv),
    .ONOFF_OUT_O(onoff), .PID_REINIT_O(reinit), .PID_SEED_O(seed),
    .PID_SEED_VAL_O(sv), .ITIME_EFF_O(itime), .DTIME_EFF_O(dtime));
  lomsel_proc_model u_proc (.clk_i(clk), .pv_set_i(pv_set),
    .alm_set_i(alm_set), .pv_o(pv), .alm_o(alm));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] ad, input int d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no timeout here; only the watchdog ends a wait for a pready that never comes
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] ad, input int d);
    apb(1'b1, ad, d);
  endtask : wr
  task automatic rd(input logic [7:0] ad, input int e, input bit err = 0);
    expq.push_back({err, e});
    apb(1'b0, ad, 0);
  endtask : rd
  task automatic setpv(input int v, input logic [2:0] al);
    pv_set <= v[15:0];
    alm_set <= al;
    repeat (4) @(posedge clk);
  endtask : setpv
  // read results are judged where they appear on the bus
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, expq.pop_front());
    if (reinit === 1'b1) reinit_n++;
    if (seed === 1'b1) seed_n++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hdc80));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(OFS_PRESET_MAN, 0);
    rd(OFS_ONOFF_DIFF, 0);
    rd(8'h3c, 0, 1'b1);
    h = $urandom_range(1200) - 100;
    wr(OFS_RDY_HEAT, h);
    rd(OFS_MAN_MV, h);
    wr(OFS_RDY_COOL, 123);
    rd(OFS_RDY_COOL, 0);
    wr(OFS_CTRL, 32'h0000_0005);
    rd(OFS_PRESET_MAN, 500);
    rd(OFS_PID_INIT, 500);
    check(33'(sv), 33'd500);
    wr(OFS_RDY_COOL, 123);
    rd(OFS_RDY_COOL, 123);
    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_PID_INIT, 0);
    r = $urandom_range(1200) - 100;
    wr(OFS_PID_MV, r);
    wr(OFS_PRESET_MAN, 700);
    wr(OFS_CTRL, 32'h0000_0201);
    wr(OFS_CTRL, 32'h0000_0301);
    rd(OFS_MAN_MV, r);
    wr(OFS_CTRL, 32'h0000_0201);
    wr(OFS_CTRL, 32'h0000_0311);
    rd(OFS_MAN_MV, 700);
    a = $urandom_range(1200) - 100;
    wr(OFS_ALM_OUT, a);
    for (i = 0; i < 3; i++) begin
      setpv(0, 3'(1 << i));
      wr(OFS_CTRL, 32'h0000_0201);
      rd(OFS_MAN_MV, r);
      wr(OFS_CTRL, 32'h0000_0209);
      rd(OFS_MAN_MV, a);
    end
    wr(OFS_CTRL, 32'h0000_0009);
    rd(OFS_MAN_MV, h);
    setpv(0, 3'h0);
    wr(OFS_CTRL, 32'h0000_0241);
    wr(OFS_SETPOINT, 10);
    wr(OFS_CTRL, 32'h0000_0221);
    wr(OFS_SETPOINT, 20);
    wr(OFS_CTRL, 32'h0000_0201);
    wr(OFS_SP_GROUP, 1);
    wr(OFS_SETPOINT, 30);
    wr(OFS_CTRL, 32'h0000_0261);
    rd(OFS_CTRL, 32'h0000_0201);
    check(33'(reinit_n), 33'h2);
    check(33'(itime), 33'h4b0);
    wr(OFS_ITIME, 10000);
    repeat (2) @(posedge clk);
    check(33'(itime), 33'h1_8696);
    wr(OFS_ITIME, 120);
    wr(OFS_CTRL, 32'h0000_0281);
    repeat (2) @(posedge clk);
    check(33'(itime), 33'h78);
    check(33'(dtime), 33'h1e);
    rd(OFS_ITIME, 120);
    wr(OFS_CTRL, 32'h0000_0200);
    rd(OFS_ONOFF_DIFF, 5);
    wr(OFS_ONOFF_ONOFF_POINT_OFFSET, 10000);
    rd(OFS_ONOFF_ONOFF_POINT_OFFSET, 9999);
    wr(OFS_ONOFF_DIFF, 15);
    wr(OFS_ONOFF_ONOFF_POINT_OFFSET, 5);
    wr(OFS_SETPOINT, 200);
    for (i = 0; i < 10; i++) begin
      if (i == 5) begin
        wr(OFS_CTRL, 32'h0000_0202);
        wr(OFS_ONOFF_DIFF, 5);
        wr(OFS_ONOFF_ONOFF_POINT_OFFSET, -5);
        wr(OFS_SETPOINT, 10);
      end
      setpv(pvs[i], 3'h0);
      check(33'(onoff), 33'(on_pat[i]));
      rd(OFS_MAN_MV, on_pat[i] ? 1000 : 0);
    end
    check(33'(seed_n), 33'h2);
    tally_and_finish();
  end
endmodule : lomsel_tb_top
